// ### verilog/pwm_timer.sv
/*
 * Pulse width modulation timer channel with register port and interrupt.
 * Assumes pins are asynchronous; register master on clk.
 */
`timescale 1ns/10ps
module pwm_timer
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Pins and events
    input wire logic trigger_input_pin,
    input wire logic subclock,
    input wire logic other_overflow,
    output logic pulse_output_pin,
    output logic pulse_output_oe,
    output logic port_out,
    // Interrupt
    output logic irq
);
    // ****************************************
    // Declarations
    // ****************************************
    tick_if tk ();
    pwm_pkg::state_t state;
    pwm_pkg::state_t next_state;
    logic [8:0] ctrl;
    logic [8:0] next_ctrl;
    logic [15:0] reload;
    logic [15:0] next_reload;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [7:0] pre;
    logic [7:0] next_pre;
    logic [15:0] phase;
    logic [15:0] next_phase;
    logic wave;
    logic next_wave;
    logic [1:0] status;
    logic [1:0] next_status;
    logic [1:0] mask;
    logic [1:0] next_mask;
    logic port_reg;
    logic next_port_reg;
    logic [31:0] next_rdata;
    logic [1:0] trig_sync;
    logic [1:0] sub_sync;
    logic trig_prev;
    logic sub_prev;
    logic sub_edge;
    logic trig_edge;
    logic start_evt;
    logic fall_evt;
    logic [15:0] hi_len;
    logic [15:0] period_len;
    logic period_end;
    logic period_start;
    logic stop_req;

    assign tk.src = ctrl[pwm_pkg::CTRL_SRC_LO +: 2];

    count_source u_count_source
    (
        .clk(clk),
        .rstn(rstn),
        .sub_edge(sub_edge),
        .tk(tk)
    );

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            trig_sync <= 2'h0;
            sub_sync <= 2'h0;
            trig_prev <= 1'b0;
            sub_prev <= 1'b0;
        end
        else
        begin
            trig_sync <= {trig_sync[0], trigger_input_pin};
            sub_sync <= {sub_sync[0], subclock};
            trig_prev <= trig_sync[1];
            sub_prev <= sub_sync[1];
        end
    end

    assign sub_edge = sub_sync[1] && !sub_prev;
    // Trigger polarity select; pin is a plain port when trigger disabled
    assign trig_edge = ctrl[pwm_pkg::CTRL_TRIG_EN] && (ctrl[pwm_pkg::CTRL_TRIG_RISE] ?
        (trig_sync[1] && !trig_prev) : (!trig_sync[1] && trig_prev));
    assign start_evt = trig_edge || (ctrl[pwm_pkg::CTRL_OVF_EN] && other_overflow);

    // ****************************************
    // Waveform geometry
    // ****************************************
    always_comb
    begin
        if (ctrl[pwm_pkg::CTRL_MODE8])
        begin
            hi_len = {8'h00, cnt[15:8]};
            period_len = {8'h00, pwm_pkg::PERIOD8};
        end
        else
        begin
            hi_len = cnt;
            period_len = pwm_pkg::PERIOD16;
        end
    end

    // A unit step is one tick (16-bit) or m+1 ticks (8-bit)
    assign period_end = (state == pwm_pkg::ST_RUN) && tk.tick && (phase == 16'h0001) &&
        (!ctrl[pwm_pkg::CTRL_MODE8] || pre == 8'h00);
    assign period_start = period_end;
    assign fall_evt = wave && tk.tick && (!ctrl[pwm_pkg::CTRL_MODE8] || pre == 8'h00) &&
        (period_len - phase + 16'h0001 == hi_len);

    // ****************************************
    // Channel state
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_pre = pre;
        next_phase = phase;
        next_wave = wave;
        unique case (state)
            pwm_pkg::ST_IDLE:
            begin
                next_wave = 1'b0;
                if (ctrl[pwm_pkg::CTRL_START] || start_evt)
                begin
                    next_state = pwm_pkg::ST_RUN;
                    next_cnt = reload;
                    next_pre = reload[7:0];
                    next_phase = period_len;
                    next_wave = (ctrl[pwm_pkg::CTRL_MODE8] ? {8'h00, reload[15:8]} : reload) != 16'h0000;
                end
            end
            pwm_pkg::ST_RUN:
            begin
                if (tk.tick)
                begin
                    if (ctrl[pwm_pkg::CTRL_MODE8] && pre != 8'h00)
                    begin
                        next_pre = pre - 8'h01;
                    end
                    else
                    begin
                        next_pre = cnt[7:0];
                        next_phase = phase - 16'h0001;
                        if (fall_evt)
                        begin
                            next_wave = 1'b0;
                        end
                        if (period_end)
                        begin
                            next_cnt = reload;
                            next_pre = reload[7:0];
                            next_phase = period_len;
                            next_wave = (ctrl[pwm_pkg::CTRL_MODE8] ? {8'h00, reload[15:8]} : reload) != 16'h0000;
                        end
                    end
                end
                if (stop_req)
                begin
                    next_state = pwm_pkg::ST_IDLE;
                    next_wave = 1'b0;
                end
            end
            default:
            begin
                next_state = pwm_pkg::ST_IDLE;
            end
        endcase
        if (wr && addr == pwm_pkg::ADDR_VALUE && state == pwm_pkg::ST_IDLE)
        begin
            next_cnt = wdata[15:0];
        end
    end

    // Start flag written to zero stops the channel
    assign stop_req = wr && addr == pwm_pkg::ADDR_CTRL && !wdata[pwm_pkg::CTRL_START];

    // ****************************************
    // Registers
    // ****************************************
    always_comb
    begin
        next_ctrl = ctrl;
        next_reload = reload;
        next_mask = mask;
        next_port_reg = port_reg;
        next_status = status | {fall_evt, period_start};
        next_rdata = 32'h0000_0000;
        if (wr)
        begin
            unique case (addr)
                pwm_pkg::ADDR_VALUE: next_reload = wdata[15:0];
                pwm_pkg::ADDR_CTRL: next_ctrl = wdata[8:0];
                pwm_pkg::ADDR_STATUS: next_status = (status & ~wdata[1:0]) | {fall_evt, period_start};
                pwm_pkg::ADDR_MASK: next_mask = wdata[1:0];
                pwm_pkg::ADDR_PORT: next_port_reg = wdata[0];
                default: next_ctrl = ctrl;
            endcase
        end
        if (state == pwm_pkg::ST_IDLE && start_evt)
        begin
            // Only a stopped channel takes a start event
            next_ctrl[pwm_pkg::CTRL_START] = 1'b1;
        end
        if (rd)
        begin
            unique case (addr)
                pwm_pkg::ADDR_VALUE: next_rdata = pwm_pkg::UNDEF_READ;
                pwm_pkg::ADDR_CTRL: next_rdata = {23'h000000, ctrl};
                pwm_pkg::ADDR_STATUS: next_rdata = {28'h0000000, state == pwm_pkg::ST_RUN, wave, status};
                pwm_pkg::ADDR_MASK: next_rdata = {30'h00000000, mask};
                pwm_pkg::ADDR_PORT: next_rdata = {31'h00000000, trig_sync[1]};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= pwm_pkg::ST_IDLE;
            ctrl <= pwm_pkg::CTRL_RESET;
            reload <= pwm_pkg::VALUE_RESET;
            cnt <= pwm_pkg::VALUE_RESET;
            pre <= 8'h00;
            phase <= 16'h0000;
            wave <= 1'b0;
            status <= 2'h0;
            mask <= 2'h0;
            port_reg <= 1'b0;
            rdata <= 32'h0000_0000;
            pulse_output_pin <= 1'b0;
            pulse_output_oe <= 1'b0;
            port_out <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ctrl <= next_ctrl;
            reload <= next_reload;
            cnt <= next_cnt;
            pre <= next_pre;
            phase <= next_phase;
            wave <= next_wave;
            status <= next_status;
            mask <= next_mask;
            port_reg <= next_port_reg;
            rdata <= next_rdata;
            // Both selects pick the timer, otherwise the general port
            pulse_output_pin <= (ctrl[pwm_pkg::CTRL_SEL_A] && ctrl[pwm_pkg::CTRL_SEL_B]) ?
                next_wave : next_port_reg;
            pulse_output_oe <= 1'b1;
            port_out <= next_port_reg;
            irq <= |(next_status & next_mask);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_written_idle;
        wr && addr == pwm_pkg::ADDR_VALUE && state == pwm_pkg::ST_IDLE;
    endsequence
    sequence s_stop_write;
        state == pwm_pkg::ST_RUN && wr && addr == pwm_pkg::ADDR_CTRL && !wdata[pwm_pkg::CTRL_START];
    endsequence
    sequence s_sw_start;
        state == pwm_pkg::ST_IDLE && ctrl[pwm_pkg::CTRL_START];
    endsequence

    chk_idle_low: assert property (@(posedge clk) disable iff (!rstn)
        state == pwm_pkg::ST_IDLE |-> !wave)
        else $error("wave high while stopped");
    chk_stop_flag: assert property (@(posedge clk) disable iff (!rstn)
        (state == pwm_pkg::ST_RUN && wr && addr == pwm_pkg::ADDR_CTRL && !wdata[0]) |=>
        state == pwm_pkg::ST_IDLE)
        else $error("did not stop");
    chk_idle_load: assert property (@(posedge clk) disable iff (!rstn)
        s_written_idle |=> (cnt == $past(wdata[15:0]) && reload == $past(wdata[15:0])))
        else $error("idle write not loaded");
    chk_run_load: assert property (@(posedge clk) disable iff (!rstn)
        (state == pwm_pkg::ST_RUN && wr && addr == pwm_pkg::ADDR_VALUE && !period_end) |=>
        (reload == $past(wdata[15:0]) && cnt == $past(cnt)))
        else $error("run write touched counter");
    chk_reload: assert property (@(posedge clk) disable iff (!rstn)
        (state == pwm_pkg::ST_RUN && period_end && !stop_req) |=> cnt == $past(reload))
        else $error("no reload at period");
    chk_trig_ignored: assert property (@(posedge clk) disable iff (!rstn)
        (state == pwm_pkg::ST_RUN && start_evt && !tk.tick && !wr) |=> phase == $past(phase))
        else $error("trigger disturbed count");
    chk_fall_irq: assert property (@(posedge clk) disable iff (!rstn)
        (wave && !next_wave && state == pwm_pkg::ST_RUN && !stop_req) |=> status[1])
        else $error("fall not flagged");
    chk_irq_level: assert property (@(posedge clk) disable iff (!rstn)
        (status[1] && mask[1]) |-> irq)
        else $error("irq low with pending");
    chk_undef_read: assert property (@(posedge clk) disable iff (!rstn)
        (rd && addr == pwm_pkg::ADDR_VALUE) |=> rdata == pwm_pkg::UNDEF_READ)
        else $error("value read wrong");
    chk_trig_start: assert property (@(posedge clk) disable iff (!rstn)
        (state == pwm_pkg::ST_IDLE && start_evt) |=> state == pwm_pkg::ST_RUN)
        else $error("trigger did not start");

    chk_stop_quiet: assert property (@(posedge clk) disable iff (!rstn)
        s_stop_write |=> (state == pwm_pkg::ST_IDLE && !wave))
        else $error("stop left wave high");
    chk_sw_start: assert property (@(posedge clk) disable iff (!rstn)
        s_sw_start |=> state == pwm_pkg::ST_RUN)
        else $error("start flag did not start");
    chk_count_down: assert property (@(posedge clk) disable iff (!rstn)
        (state == pwm_pkg::ST_RUN && tk.tick && !ctrl[pwm_pkg::CTRL_MODE8] && !period_end && !wr) |=>
        phase == $past(phase) - 16'h0001)
        else $error("counter did not step down");
    chk_pin_timer: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl[pwm_pkg::CTRL_SEL_A] && ctrl[pwm_pkg::CTRL_SEL_B]) |=> pulse_output_pin == wave)
        else $error("pin not showing waveform");
    chk_pin_port: assert property (@(posedge clk) disable iff (!rstn)
        !(ctrl[pwm_pkg::CTRL_SEL_A] && ctrl[pwm_pkg::CTRL_SEL_B]) |=> pulse_output_pin == port_reg)
        else $error("pin not showing port");
    chk_start_high: assert property (@(posedge clk) disable iff (!rstn)
        (state == pwm_pkg::ST_IDLE && next_state == pwm_pkg::ST_RUN && !ctrl[pwm_pkg::CTRL_MODE8] &&
        reload != 16'h0000) |=> wave)
        else $error("period did not start high");
    chk_period_flag: assert property (@(posedge clk) disable iff (!rstn)
        (state == pwm_pkg::ST_RUN && period_end) |=> status[0])
        else $error("period start not flagged");
endmodule // pwm_timer

// ### verilog/pwm_pkg.sv
/*
 * Constants shared by the pulse width modulation timer channel.
 * Assumes a single 200 MHz clock and a plain register port.
 */
package pwm_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] ADDR_VALUE = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_PORT = 4'h4;
    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE8 = 1;
    localparam int CTRL_SRC_LO = 2;
    localparam int CTRL_TRIG_EN = 4;
    localparam int CTRL_OVF_EN = 5;
    localparam int CTRL_TRIG_RISE = 6;
    localparam int CTRL_SEL_A = 7;
    localparam int CTRL_SEL_B = 8;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    // ****************************************
    // Count sources
    // ****************************************
    localparam logic [1:0] SRC_F1 = 2'h0;
    localparam logic [1:0] SRC_F8 = 2'h1;
    localparam logic [1:0] SRC_F32 = 2'h2;
    localparam logic [1:0] SRC_SUBCLOCK_DIV32_SOURCE = 2'h3;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1f;
    // ****************************************
    // Waveform periods in unit steps
    // ****************************************
    localparam logic [15:0] PERIOD16 = 16'hffff;
    localparam logic [7:0] PERIOD8 = 8'hff;
    localparam logic [31:0] UNDEF_READ = 32'hdeadbeef;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } state_t;
endpackage

// ### verilog/tick_if.sv
/*
 * Interface carrying count-source ticks to the channel.
 * Assumes producer and consumer share clk.
 */
`timescale 1ns/10ps
interface tick_if;
    logic [1:0] src;
    logic tick;
    modport prescaler (input src, output tick);
    modport channel (output src, input tick);
endinterface

// ### verilog/count_source.sv
/*
 * Count-source divider: one-cycle tick enables.
 * Assumes subclock edge input already synchronised.
 */
`timescale 1ns/10ps
module count_source
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Subclock rising-edge pulse
    input wire logic sub_edge,
    // Tick port
    tick_if.prescaler tk
);
    logic [4:0] div_cnt;
    logic [4:0] next_div_cnt;
    logic [4:0] sub_cnt;
    logic [4:0] next_sub_cnt;
    logic next_tick;

    always_comb
    begin
        next_div_cnt = div_cnt + 5'h01;
        next_sub_cnt = sub_cnt;
        if (sub_edge)
        begin
            next_sub_cnt = sub_cnt + 5'h01;
        end
        unique case (tk.src)
            pwm_pkg::SRC_F1: next_tick = 1'b1;
            pwm_pkg::SRC_F8: next_tick = (div_cnt[2:0] == pwm_pkg::DIV8_LAST[2:0]);
            pwm_pkg::SRC_F32: next_tick = (div_cnt == pwm_pkg::DIV32_LAST);
            default: next_tick = sub_edge && (sub_cnt == pwm_pkg::DIV32_LAST);
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_cnt <= 5'h00;
            sub_cnt <= 5'h00;
            tk.tick <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            sub_cnt <= next_sub_cnt;
            tk.tick <= next_tick;
        end
    end

    chk_f8_spacing: assert property (@(posedge clk) disable iff (!rstn)
        (tk.src == pwm_pkg::SRC_F8 && $past(tk.src) == pwm_pkg::SRC_F8 && tk.tick) |=>
        (!tk.tick || tk.src != pwm_pkg::SRC_F8))
        else $error("clock/8 ticks too close");
endmodule // count_source

// ### dv/pwm_far_side.sv
/*
 * Far-side model: trigger pin, other-timer overflow and a free subclock.
 * Assumes the bench raises its requests on clk rising edges.
 */
`timescale 1ns/10ps
module pwm_far_side
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bench requests
    input wire logic trig_level,
    input wire logic ovf_go,
    // Pins to the channel
    output logic trigger_input_pin,
    output logic other_overflow,
    output logic subclock
);
    logic [1:0] sub_cnt;
    // **********
    // Pin drivers
    // **********
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sub_cnt <= 2'h0;
            subclock <= 1'b0;
            trigger_input_pin <= 1'b0;
            other_overflow <= 1'b0;
        end
        else
        begin
            sub_cnt <= sub_cnt + 2'h1;
            // Subclock runs free at clk/8
            if (sub_cnt == 2'h3)
                subclock <= ~subclock;
            trigger_input_pin <= trig_level;
            other_overflow <= ovf_go;
        end
    end
endmodule // pwm_far_side

// ### dv/timer_a_pwm_mode_bench.sv
/*
 * Self-checking bench for the pwm_timer channel.
 * Assumes pwm_pkg, tick_if and the design modules compile first.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module timer_a_pwm_mode_bench;
    // **********
    // Signals
    // **********
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic trig_level = 1'b0;
    logic ovf_go = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic trig_pin, sub_clk, ovf, pwm, oe, port_out, irq;
    int mismatches = 0;
    int compares = 0;
    int hi, lo, x;
    localparam logic [3:0] A_VAL = pwm_pkg::ADDR_VALUE;
    localparam logic [3:0] A_CTL = pwm_pkg::ADDR_CTRL;
    localparam logic [3:0] A_STA = pwm_pkg::ADDR_STATUS;
    localparam logic [3:0] A_MSK = pwm_pkg::ADDR_MASK;
    localparam logic [3:0] A_PRT = pwm_pkg::ADDR_PORT;
    localparam logic [31:0] C_ST = 32'h1 << pwm_pkg::CTRL_START;
    localparam logic [31:0] C_M8 = 32'h1 << pwm_pkg::CTRL_MODE8;
    localparam logic [31:0] C_TRG = (32'h1 << pwm_pkg::CTRL_TRIG_EN) | (32'h1 << pwm_pkg::CTRL_TRIG_RISE);
    localparam logic [31:0] C_OVF = 32'h1 << pwm_pkg::CTRL_OVF_EN;
    localparam logic [31:0] C_SA = 32'h1 << pwm_pkg::CTRL_SEL_A;
    localparam logic [31:0] C_PIN = C_SA | (32'h1 << pwm_pkg::CTRL_SEL_B);
    localparam logic [31:0] C_RUN8 = C_PIN | C_M8 | C_ST;
    always #2.5 clk = ~clk;
    // **********
    // Instances
    // **********
    pwm_timer dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .trigger_input_pin(trig_pin), .subclock(sub_clk), .other_overflow(ovf), .pulse_output_pin(pwm),
        .pulse_output_oe(oe), .port_out(port_out), .irq(irq));
    pwm_far_side far_side (.clk(clk), .rstn(rstn), .trig_level(trig_level), .ovf_go(ovf_go),
        .trigger_input_pin(trig_pin), .other_overflow(ovf), .subclock(sub_clk));
    // **********
    // Tasks
    // **********
    function automatic logic [31:0] src(input logic [1:0] s);
        return 32'(s) << pwm_pkg::CTRL_SRC_LO;
    endfunction
    task ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task edge_cnt(input logic v, input int lim, output int n);
        n = 0;
        while (pwm !== v && n < lim)
        begin
            ticks(1);
            n++;
        end
    endtask
    // Skips the first period, whose first tick may come early
    task measure(input logic [31:0] ctl, input logic [31:0] val);
        wr_reg(A_VAL, val);
        wr_reg(A_CTL, ctl);
        edge_cnt(1'b1, 20000, x);
        edge_cnt(1'b0, 20000, x);
        edge_cnt(1'b1, 20000, x);
        edge_cnt(1'b0, 20000, hi);
        edge_cnt(1'b1, 20000, lo);
    endtask
    task halt;
        wr_reg(A_CTL, C_PIN);
        ticks(4);
    endtask
    task give_verdict;
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // **********
    // Scenarios
    // **********
    task t_reset;
        `CHK("pin idle", 1'b0, pwm)
        `CHK("oe", 1'b1, oe)
        `CHK("irq idle", 1'b0, irq)
        rd_reg(A_VAL);
        `CHK("value read", pwm_pkg::UNDEF_READ, d)
        rd_reg(4'hf);
        `CHK("unmapped", 32'h0, d)
    endtask
    task t_modes;
        measure(C_RUN8, 32'h0301);
        `CHK("8b high", 6, hi)
        `CHK("8b period", 510, hi + lo)
        halt();
        measure(C_RUN8 | src(pwm_pkg::SRC_F8), 32'h0200);
        `CHK("div8 high", 16, hi)
        `CHK("div8 period", 2040, hi + lo)
        halt();
        measure(C_RUN8 | src(pwm_pkg::SRC_F32), 32'h0200);
        `CHK("div32 high", 64, hi)
        `CHK("div32 period", 8160, hi + lo)
        halt();
        wr_reg(A_CTL, C_RUN8 | src(pwm_pkg::SRC_SUBCLOCK_DIV32_SOURCE));
        edge_cnt(1'b1, 1000, lo);
        edge_cnt(1'b0, 1000, hi);
        `CHK("sub high", 1'b1, hi >= 256 && hi <= 520)
        halt();
        wr_reg(A_VAL, 32'h0014);
        wr_reg(A_CTL, C_PIN | C_ST);
        edge_cnt(1'b1, 50, lo);
        edge_cnt(1'b0, 50, hi);
        `CHK("16b high", 20, hi)
        edge_cnt(1'b1, 2000, lo);
        `CHK("16b long low", 2000, lo)
        halt();
    endtask
    task t_write;
        wr_reg(A_VAL, 32'h0500);
        wr_reg(A_CTL, C_RUN8);
        edge_cnt(1'b1, 50, lo);
        edge_cnt(1'b0, 50, hi);
        `CHK("loaded high", 5, hi)
        wr_reg(A_VAL, 32'h0900);
        edge_cnt(1'b1, 300, lo);
        `CHK("low kept", 250, lo + 2)
        edge_cnt(1'b0, 50, hi);
        `CHK("reloaded high", 9, hi)
        halt();
    endtask
    task t_irq;
        wr_reg(A_STA, 32'h3);
        wr_reg(A_MSK, 32'h2);
        wr_reg(A_VAL, 32'h0400);
        wr_reg(A_CTL, C_RUN8);
        edge_cnt(1'b1, 50, lo);
        `CHK("irq at rise", 1'b0, irq)
        edge_cnt(1'b0, 50, hi);
        ticks(2);
        `CHK("irq at fall", 1'b1, irq)
        wr_reg(A_STA, 32'h2);
        ticks(1);
        `CHK("irq cleared", 1'b0, irq)
        wr_reg(A_MSK, 32'h0);
        edge_cnt(1'b1, 300, lo);
        edge_cnt(1'b0, 50, hi);
        ticks(2);
        `CHK("irq masked", 1'b0, irq)
        rd_reg(A_STA);
        `CHK("fall flag", 1'b1, d[1])
        wr_reg(A_STA, 32'h3);
        halt();
    endtask
    task t_trigger;
        wr_reg(A_CTL, C_PIN | C_M8 | C_TRG);
        ticks(8);
        rd_reg(A_STA);
        `CHK("no self start", 1'b0, d[3])
        @(posedge clk);
        trig_level <= 1'b1;
        ticks(8);
        rd_reg(A_STA);
        `CHK("trig start", 1'b1, d[3])
        edge_cnt(1'b1, 300, lo);
        edge_cnt(1'b0, 50, hi);
        @(posedge clk);
        trig_level <= 1'b0;
        repeat (9) @(posedge clk);
        trig_level <= 1'b1;
        ticks(10);
        edge_cnt(1'b1, 300, lo);
        `CHK("retrigger ignored", 251, lo + 20)
        halt();
        rd_reg(A_PRT);
        `CHK("port in high", 1'b1, d[0])
        rd_reg(A_STA);
        `CHK("port no start", 1'b0, d[3])
        @(posedge clk);
        trig_level <= 1'b0;
        ticks(6);
        rd_reg(A_PRT);
        `CHK("port in low", 1'b0, d[0])
        wr_reg(A_CTL, C_PIN | C_M8 | C_OVF);
        @(posedge clk);
        ovf_go <= 1'b1;
        @(posedge clk);
        ovf_go <= 1'b0;
        ticks(4);
        rd_reg(A_STA);
        `CHK("ovf start", 1'b1, d[3])
        halt();
        @(posedge clk);
        trig_level <= 1'b1;
        wr_reg(A_CTL, C_PIN | C_M8 | (32'h1 << pwm_pkg::CTRL_TRIG_EN));
        ticks(6);
        rd_reg(A_STA);
        `CHK("no start on rise", 1'b0, d[3])
        @(posedge clk);
        trig_level <= 1'b0;
        ticks(8);
        rd_reg(A_STA);
        `CHK("fall trig start", 1'b1, d[3])
        halt();
    endtask
    task t_stop_pins;
        wr_reg(A_VAL, 32'hc800);
        wr_reg(A_CTL, C_RUN8);
        edge_cnt(1'b1, 50, lo);
        ticks(10);
        wr_reg(A_CTL, C_PIN);
        edge_cnt(1'b0, 10, hi);
        `CHK("stop drops pin", 1'b1, hi < 10)
        rd_reg(A_STA);
        `CHK("stopped", 1'b0, d[3])
        edge_cnt(1'b1, 600, lo);
        `CHK("stays low", 600, lo)
        wr_reg(A_VAL, 32'h0400);
        wr_reg(A_CTL, C_SA | C_M8 | C_ST);
        edge_cnt(1'b1, 600, lo);
        `CHK("pin as port", 600, lo)
        wr_reg(A_PRT, 32'h1);
        ticks(2);
        `CHK("port drive", 1'b1, pwm)
        `CHK("port out", 1'b1, port_out)
        wr_reg(A_PRT, 32'h0);
        halt();
    endtask
    // **********
    // Main
    // **********
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        ticks(2);
        t_reset();
        t_modes();
        t_write();
        t_irq();
        t_trigger();
        t_stop_pins();
        give_verdict();
    end
    initial
    begin
        #300000;
        mismatches++;
        give_verdict();
    end
endmodule // timer_a_pwm_mode_bench
